/* File: rtl/pmx_pad_matrix.sv */
`default_nettype none

// Operation
// - Each peripheral input in a listed range has its own selector naming any input pad.
// - Each pad's matrix output picks any one peripheral output signal.
// - Pads 34-39 never drive; only listed output pads may enable.
// - One configuration word per pad selects matrix or direct function.
// - Direct function wires pad straight to its fast peripheral.
// - Pad reaches matrix only when its function field equals 2.
// - Input enable clear blocks the pad value from going inward.
// - Pull-up and pull-down bits switch the pad resistors.
// - Source bit set makes a matrix pad's enable follow its software bit only; direct pads keep their fast enable.
// - Software enables sit in two words, pads 0-31 and 32-39.
// - Per-input inversion flips the routed value before the peripheral.
// - Selector 0x30 gives constant 0, 0x38 gives constant 1.
// - One pad may feed several peripheral inputs at once.
// - Only documented index ranges own selectors; others read zero.
// - Two read words report every pad input value, one bit each.
// - Pad values readable anytime, valid only while input enabled.
module pmx_pad_matrix #(
	parameter int NUM_PADS = pmx_pkg::PMX_NUM_PADS,
	parameter int NUM_IN   = pmx_pkg::PMX_NUM_IN,
	parameter int NUM_OUT  = pmx_pkg::PMX_NUM_OUT
) (
	input  wire logic                                   CORE_CLK_IN,
	input  wire logic                                   RST_IN,
	input  wire logic [pmx_pkg::PMX_NUM_PADS-1:0]       PAD_IN_IN,
	input  wire pmx_pkg::pmx_pad_cfg_t
		[pmx_pkg::PMX_NUM_PADS-1:0]                      PAD_CFG_IN,
	input  wire pmx_pkg::pmx_out_cfg_t
		[pmx_pkg::PMX_NUM_PADS-1:0]                      OUT_ROUTE_IN,
	input  wire pmx_pkg::pmx_in_cfg_t
		[pmx_pkg::PMX_NUM_IN-1:0]                        IN_ROUTE_IN,
	input  wire logic [pmx_pkg::PMX_OE_LO_W-1:0]        OE_LO_IN,
	input  wire logic [pmx_pkg::PMX_OE_HI_W-1:0]        OE_HI_IN,
	input  wire logic [pmx_pkg::PMX_NUM_OUT-1:0]        PERIPH_OUT_IN,
	input  wire logic [pmx_pkg::PMX_NUM_OUT-1:0]        PERIPH_OE_IN,
	input  wire logic [pmx_pkg::PMX_NUM_PADS-1:0]       DIRECT_OUT_IN,
	input  wire logic [pmx_pkg::PMX_NUM_PADS-1:0]       DIRECT_OE_IN,
	output logic      [pmx_pkg::PMX_NUM_IN-1:0]         PERIPH_IN_OUT,
	output logic      [pmx_pkg::PMX_NUM_PADS-1:0]       DIRECT_IN_OUT,
	output logic      [pmx_pkg::PMX_NUM_PADS-1:0]       PAD_OUT_OUT,
	output logic      [pmx_pkg::PMX_NUM_PADS-1:0]       PAD_OE_OUT,
	output logic      [pmx_pkg::PMX_NUM_PADS-1:0]       PAD_PU_OUT,
	output logic      [pmx_pkg::PMX_NUM_PADS-1:0]       PAD_PD_OUT,
	output logic      [pmx_pkg::PMX_OE_LO_W-1:0]        PAD_VAL_LO_OUT,
	output logic      [pmx_pkg::PMX_OE_HI_W-1:0]        PAD_VAL_HI_OUT
);
	import pmx_pkg::*;

	// ---------------------------------------------------------------
	// Elaboration checks
	// ---------------------------------------------------------------
	if (NUM_PADS != PMX_NUM_PADS) begin : g_chk_pads
		$error("pad count must match the package");
	end
	if (NUM_IN != PMX_NUM_IN) begin : g_chk_in
		$error("input count must match the package");
	end
	if (NUM_OUT != PMX_NUM_OUT) begin : g_chk_out
		$error("output count must match the package");
	end
	if (PMX_OE_LO_W + PMX_OE_HI_W != NUM_PADS) begin : g_chk_oe
		$error("enable words must cover every pad");
	end

	// ---------------------------------------------------------------
	// Signals
	// ---------------------------------------------------------------
	pmx_state_t              st_q;
	pmx_state_t              st_d;
	logic [NUM_PADS-1:0]     pad_live;
	logic [NUM_PADS-1:0]     matrix_pads;
	logic [NUM_PADS-1:0]     sw_oe;
	logic [NUM_IN-1:0]       route_val;

	// Software enable bits as one vector, low word then high word
	assign sw_oe = {OE_HI_IN, OE_LO_IN};

	// ---------------------------------------------------------------
	// Inward pad path
	// ---------------------------------------------------------------

	// Input gating per pad and split between matrix and direct use
	always_comb begin
		pad_live    = '0;
		matrix_pads = '0;
		for (int p = 0; p < NUM_PADS; p++) begin
			// Missing pads and disabled inputs never pass inward
			pad_live[p] = PAD_IN_IN[p] & PMX_IN_CAPABLE[p]
				& PAD_CFG_IN[p].ie;
			if (PAD_CFG_IN[p].func_sel == PMX_FUNC_MATRIX) begin
				matrix_pads[p] = pad_live[p];
			end
		end
	end

	// One selector per peripheral input; unlisted indices stay low
	for (genvar i = 0; i < NUM_IN; i++) begin : g_in
		pmx_in_route #(
			.ROUTABLE (pmx_in_routable(i))
		) u_route (
			.cfg_in  (IN_ROUTE_IN[i]),
			.pads_in (matrix_pads),
			.val_out (route_val[i])
		);
	end

	// ---------------------------------------------------------------
	// State update
	// ---------------------------------------------------------------

	// Next state of every registered output
	always_comb begin
		logic            m_out;
		logic            m_oe;
		logic [7:0]      osel;
		st_d  = st_q;
		m_out = 1'b0;
		m_oe  = 1'b0;
		osel  = '0;
		st_d.periph_in = route_val;
		st_d.pad_val   = pad_live;
		for (int p = 0; p < NUM_PADS; p++) begin
			osel  = OUT_ROUTE_IN[p].out_sel;
			m_out = 1'b0;
			m_oe  = 1'b0;
			if (osel < PMX_OSEL_W'(NUM_OUT)) begin
				m_out = PERIPH_OUT_IN[osel];
				m_oe  = PERIPH_OE_IN[osel];
			end
			if (OUT_ROUTE_IN[p].oen_sel) begin
				m_oe = sw_oe[p];
			end
			if (PAD_CFG_IN[p].func_sel == PMX_FUNC_MATRIX) begin
				st_d.pad_out[p]   = m_out;
				st_d.pad_oe[p]    = m_oe & PMX_OUT_CAPABLE[p];
				st_d.direct_in[p] = 1'b0;
			end else begin
				// Fast path skips the matrix in both directions
				st_d.pad_out[p]   = DIRECT_OUT_IN[p];
				st_d.pad_oe[p]    = DIRECT_OE_IN[p]
					& PMX_OUT_CAPABLE[p];
				st_d.direct_in[p] = pad_live[p];
			end
			st_d.pad_pu[p] = PAD_CFG_IN[p].wpu;
			st_d.pad_pd[p] = PAD_CFG_IN[p].wpd;
		end
	end

	// State register
	always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			st_q <= PMX_STATE_RST;
		end else begin
			st_q <= st_d;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------

	// All outputs come straight from the state register
	assign PERIPH_IN_OUT  = st_q.periph_in;
	assign DIRECT_IN_OUT  = st_q.direct_in;
	assign PAD_OUT_OUT    = st_q.pad_out;
	assign PAD_OE_OUT     = st_q.pad_oe;
	assign PAD_PU_OUT     = st_q.pad_pu;
	assign PAD_PD_OUT     = st_q.pad_pd;
	assign PAD_VAL_LO_OUT = st_q.pad_val[PMX_OE_LO_W-1:0];
	assign PAD_VAL_HI_OUT = st_q.pad_val[NUM_PADS-1:PMX_OE_LO_W];

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb_a @(posedge CORE_CLK_IN);
	endclocking
	default disable iff (RST_IN);

	// Taps on the route of input 0 and the output pick of pad 0
	logic            tap_pad_val;
	logic            tap_pad_mtx;
	logic            tap_per_out;
	logic            tap_per_oe;
	pmx_in_cfg_t     tap_cfg;
	pmx_pad_cfg_t    tap_pad_cfg;

	// Helper picks for the tapped routes
	always_comb begin
		tap_cfg     = IN_ROUTE_IN[0];
		tap_pad_val = 1'b0;
		tap_pad_mtx = 1'b0;
		tap_pad_cfg = '0;
		tap_per_out = 1'b0;
		tap_per_oe  = 1'b0;
		if (tap_cfg.sel < PMX_SEL_W'(NUM_PADS)) begin
			tap_pad_val = PAD_IN_IN[tap_cfg.sel];
			tap_pad_cfg = PAD_CFG_IN[tap_cfg.sel];
			tap_pad_mtx = PMX_IN_CAPABLE[tap_cfg.sel]
				& tap_pad_cfg.ie
				& (tap_pad_cfg.func_sel == PMX_FUNC_MATRIX);
		end
		if (OUT_ROUTE_IN[0].out_sel < PMX_OSEL_W'(NUM_OUT)) begin
			tap_per_out = PERIPH_OUT_IN[OUT_ROUTE_IN[0].out_sel];
			tap_per_oe  = PERIPH_OE_IN[OUT_ROUTE_IN[0].out_sel];
		end
	end

	// Pad 0 configured for the matrix with a valid output pick
	sequence s_pad0_matrix;
		!RST_IN && PAD_CFG_IN[0].func_sel == PMX_FUNC_MATRIX
			&& OUT_ROUTE_IN[0].out_sel < PMX_OSEL_W'(NUM_OUT);
	endsequence

	// Input 0 reading a live matrix pad
	sequence s_in0_live;
		!RST_IN && tap_pad_mtx && tap_cfg.sel < PMX_SEL_W'(NUM_PADS);
	endsequence

	const_zero_a: assert property (
		!RST_IN && tap_cfg.sel == PMX_SEL_CONST0
		|=> PERIPH_IN_OUT[0] == $past(tap_cfg.inv))
		else $error("code 0x30 did not give constant zero");

	const_one_a: assert property (
		!RST_IN && tap_cfg.sel == PMX_SEL_CONST1
		|=> PERIPH_IN_OUT[0] == !$past(tap_cfg.inv))
		else $error("code 0x38 did not give constant one");

	route_invert_a: assert property (
		s_in0_live
		|=> PERIPH_IN_OUT[0] == ($past(tap_pad_val) ^ $past(tap_cfg.inv)))
		else $error("routed pad value or inversion wrong");

	matrix_gate_a: assert property (
		!RST_IN && tap_cfg.sel < PMX_SEL_W'(NUM_PADS) && !tap_pad_mtx
		|=> PERIPH_IN_OUT[0] == $past(tap_cfg.inv))
		else $error("pad reached matrix while not selected");

	bad_code_a: assert property (
		!RST_IN && tap_cfg.sel >= PMX_SEL_W'(NUM_PADS)
			&& tap_cfg.sel != PMX_SEL_CONST0
			&& tap_cfg.sel != PMX_SEL_CONST1
		|=> PERIPH_IN_OUT[0] == $past(tap_cfg.inv))
		else $error("unknown selector code not constant zero");

	shared_pad_a: assert property (
		!RST_IN && IN_ROUTE_IN[83] == IN_ROUTE_IN[84]
		|=> PERIPH_IN_OUT[83] == PERIPH_IN_OUT[84])
		else $error("shared pad gave inputs different values");

	dead_index_a: assert property (
		PERIPH_IN_OUT[19] == 1'b0 && PERIPH_IN_OUT[37] == 1'b0
			&& PERIPH_IN_OUT[130] == 1'b0)
		else $error("index without selector went high");

	input_only_a: assert property (
		PAD_OE_OUT[39:34] == '0 && PAD_OE_OUT[20] == 1'b0
			&& PAD_OE_OUT[31:28] == '0 && PAD_OE_OUT[24] == 1'b0)
		else $error("non-output pad enabled its driver");

	out_pick_a: assert property (
		s_pad0_matrix
		|=> PAD_OUT_OUT[0] == $past(tap_per_out))
		else $error("matrix output pick wrong on pad 0");

	sw_enable_a: assert property (
		!RST_IN && PAD_CFG_IN[32].func_sel == PMX_FUNC_MATRIX
			&& OUT_ROUTE_IN[32].oen_sel
		|=> PAD_OE_OUT[32] == $past(OE_HI_IN[0]))
		else $error("pad 32 enable ignored software bit");

	low_word_a: assert property (
		!RST_IN && PAD_CFG_IN[0].func_sel == PMX_FUNC_MATRIX
			&& OUT_ROUTE_IN[0].oen_sel && !OE_LO_IN[0]
		|=> !PAD_OE_OUT[0])
		else $error("cleared low-word bit left driver on");

	direct_path_a: assert property (
		!RST_IN && PAD_CFG_IN[5].func_sel != PMX_FUNC_MATRIX
		|=> PAD_OUT_OUT[5] == $past(DIRECT_OUT_IN[5])
			&& PAD_OE_OUT[5] == $past(DIRECT_OE_IN[5]))
		else $error("direct function not wired to pad 5");

	input_gate_a: assert property (
		!RST_IN && !PAD_CFG_IN[0].ie
		|=> !PAD_VAL_LO_OUT[0] && !DIRECT_IN_OUT[0])
		else $error("disabled pad value passed inward");

	pad_value_a: assert property (
		!RST_IN && PAD_CFG_IN[33].ie && PAD_IN_IN[33]
		|=> PAD_VAL_HI_OUT[1])
		else $error("pad 33 value missing from high word");

	pull_ctrl_a: assert property (
		!RST_IN && PAD_CFG_IN[0].wpu && !PAD_CFG_IN[0].wpd
		|=> PAD_PU_OUT[0] && !PAD_PD_OUT[0])
		else $error("pull controls not applied to pad 0");

	pull_down_a: assert property (
		!RST_IN
		|=> PAD_PD_OUT[39] == $past(PAD_CFG_IN[39].wpd))
		else $error("pull-down control not applied to pad 39");

	val_low_a: assert property (
		!RST_IN
		|=> PAD_VAL_LO_OUT[15] == $past(PAD_IN_IN[15] & PAD_CFG_IN[15].ie))
		else $error("pad 15 value wrong in low word");

	absent_pad_a: assert property (
		PAD_VAL_LO_OUT[31:28] == '0 && PAD_VAL_LO_OUT[24] == 1'b0
			&& PAD_VAL_LO_OUT[20] == 1'b0)
		else $error("missing pad reported an input value");

	high_word_a: assert property (
		!RST_IN && PAD_CFG_IN[33].func_sel == PMX_FUNC_MATRIX
			&& OUT_ROUTE_IN[33].oen_sel && !OE_HI_IN[1]
		|=> !PAD_OE_OUT[33])
		else $error("cleared high-word bit left driver on");

	periph_enable_a: assert property (
		s_pad0_matrix ##0 !OUT_ROUTE_IN[0].oen_sel
		|=> PAD_OE_OUT[0] == $past(tap_per_oe))
		else $error("peripheral enable not passed to pad 0");

	direct_input_a: assert property (
		!RST_IN && PAD_CFG_IN[5].func_sel != PMX_FUNC_MATRIX
		|=> DIRECT_IN_OUT[5] == $past(PAD_IN_IN[5] & PAD_CFG_IN[5].ie))
		else $error("pad 5 value not passed to direct input");

	direct_idle_a: assert property (
		!RST_IN && PAD_CFG_IN[5].func_sel == PMX_FUNC_MATRIX
		|=> !DIRECT_IN_OUT[5])
		else $error("matrix pad 5 still fed its direct input");

	gap_index_a: assert property (
		PERIPH_IN_OUT[60:59] == '0 && PERIPH_IN_OUT[94:91] == '0
			&& PERIPH_IN_OUT[197:196] == '0)
		else $error("unlisted input index went high");

endmodule

`default_nettype wire

/* File: rtl/pmx_pkg.sv */
`default_nettype none

package pmx_pkg;

	// ---------------------------------------------------------------
	// Sizes
	// ---------------------------------------------------------------
	localparam int PMX_NUM_PADS = 40;
	localparam int PMX_NUM_IN   = 207;
	localparam int PMX_NUM_OUT  = 176;
	localparam int PMX_SEL_W    = 6;
	localparam int PMX_OSEL_W   = 8;
	localparam int PMX_FUNC_W   = 3;
	localparam int PMX_OE_LO_W  = 32;
	localparam int PMX_OE_HI_W  = 8;

	// ---------------------------------------------------------------
	// Codes
	// ---------------------------------------------------------------
	localparam logic [PMX_FUNC_W-1:0] PMX_FUNC_MATRIX = 3'h2;
	localparam logic [PMX_SEL_W-1:0]  PMX_SEL_CONST0  = 6'h30;
	localparam logic [PMX_SEL_W-1:0]  PMX_SEL_CONST1  = 6'h38;

	// Pads that exist and may take input
	localparam logic [PMX_NUM_PADS-1:0] PMX_IN_CAPABLE  = 40'hFF_0EEF_FFFF;
	// Pads that may drive an output
	localparam logic [PMX_NUM_PADS-1:0] PMX_OUT_CAPABLE = 40'h03_0EEF_FFFF;

	// Peripheral input indices that own a selector
	localparam int PMX_NUM_RANGES = 9;
	localparam int PMX_RANGE_LO [PMX_NUM_RANGES] =
		'{0, 23, 39, 61, 95, 140, 164, 190, 198};
	localparam int PMX_RANGE_HI [PMX_NUM_RANGES] =
		'{18, 36, 58, 90, 124, 155, 181, 195, 206};

	// ---------------------------------------------------------------
	// Types
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [PMX_FUNC_W-1:0] func_sel;
		logic                  ie;
		logic                  wpu;
		logic                  wpd;
	} pmx_pad_cfg_t;

	typedef struct packed {
		logic                 inv;
		logic [PMX_SEL_W-1:0] sel;
	} pmx_in_cfg_t;

	typedef struct packed {
		logic                  oen_sel;
		logic [PMX_OSEL_W-1:0] out_sel;
	} pmx_out_cfg_t;

	typedef struct packed {
		logic [PMX_NUM_IN-1:0]   periph_in;
		logic [PMX_NUM_PADS-1:0] direct_in;
		logic [PMX_NUM_PADS-1:0] pad_out;
		logic [PMX_NUM_PADS-1:0] pad_oe;
		logic [PMX_NUM_PADS-1:0] pad_pu;
		logic [PMX_NUM_PADS-1:0] pad_pd;
		logic [PMX_NUM_PADS-1:0] pad_val;
	} pmx_state_t;

	localparam pmx_state_t PMX_STATE_RST = '0;

	// True where an input index owns a selector
	function automatic logic pmx_in_routable(input int idx);
		logic hit;
		hit = 1'b0;
		for (int r = 0; r < PMX_NUM_RANGES; r++) begin
			if (idx >= PMX_RANGE_LO[r] && idx <= PMX_RANGE_HI[r]) begin
				hit = 1'b1;
			end
		end
		return hit;
	endfunction

endpackage

`default_nettype wire

/* File: rtl/pmx_in_route.sv */
`default_nettype none

module pmx_in_route #(
	parameter bit ROUTABLE = 1'b1
) (
	input  wire pmx_pkg::pmx_in_cfg_t                cfg_in,
	input  wire logic [pmx_pkg::PMX_NUM_PADS-1:0]    pads_in,
	output logic                                     val_out
);
	import pmx_pkg::*;

	// Pad pick, constant codes, inversion
	always_comb begin
		logic raw;
		raw = 1'b0;
		if (cfg_in.sel == PMX_SEL_CONST0) begin
			raw = 1'b0;
		end else if (cfg_in.sel == PMX_SEL_CONST1) begin
			raw = 1'b1;
		end else if (cfg_in.sel < PMX_SEL_W'(PMX_NUM_PADS)) begin
			raw = pads_in[cfg_in.sel];
		end else begin
			raw = 1'b0;
		end
		val_out = ROUTABLE ? (raw ^ cfg_in.inv) : 1'b0;
	end

endmodule

`default_nettype wire

/* File: tb/pmx_far_model.sv */
`default_nettype none

// ---------------------------------------------------------------
// Far side: pad levels and peripheral drivers
// ---------------------------------------------------------------
module pmx_far_model (
	input  wire logic                             clk_in,
	output logic      [pmx_pkg::PMX_NUM_PADS-1:0] pad_out,
	output logic      [pmx_pkg::PMX_NUM_OUT-1:0]  pval_out,
	output logic      [pmx_pkg::PMX_NUM_OUT-1:0]  poe_out,
	output logic      [pmx_pkg::PMX_NUM_PADS-1:0] dval_out,
	output logic      [pmx_pkg::PMX_NUM_PADS-1:0] doe_out
);
	timeunit 1ns;
	timeprecision 1ns;
	import pmx_pkg::*;
	int           seed_m = 30193;
	logic [511:0] r;

	// Quiet levels before the first edge
	initial begin
		{pad_out, pval_out, poe_out, dval_out, doe_out} = '0;
	end

	// Pads and peripherals change freely on every rising edge
	always @(posedge clk_in) begin
		for (int i = 0; i < 16; i++) begin
			r[i*32 +: 32] = $random(seed_m);
		end
		pad_out  <= r[39:0];
		pval_out <= r[215:40];
		poe_out  <= r[391:216];
		dval_out <= r[431:392];
		doe_out  <= r[471:432];
	end
endmodule

`default_nettype wire

/* File: tb/tb.sv */
`default_nettype none

module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import pmx_pkg::*;
	// ---------------------------------------------------------------
	// Signals
	// ---------------------------------------------------------------
	logic                           clk = 1'b0;
	logic                           rst;
	int                             seed, err_count, checks, cyc;
	logic         [PMX_NUM_PADS-1:0] lvl, frc, pad_in, d_val, d_oe;
	logic         [PMX_NUM_OUT-1:0]  p_val, p_oe;
	pmx_pad_cfg_t [PMX_NUM_PADS-1:0] pcfg;
	pmx_out_cfg_t [PMX_NUM_PADS-1:0] ocfg;
	pmx_in_cfg_t  [PMX_NUM_IN-1:0]   icfg;
	logic         [PMX_OE_LO_W-1:0]  oe_lo, v_lo;
	logic         [PMX_OE_HI_W-1:0]  oe_hi, v_hi;
	logic         [PMX_NUM_IN-1:0]   o_in, e_in;
	logic         [PMX_NUM_PADS-1:0] o_din, o_out, o_oe, o_pu, o_pd;
	logic         [PMX_NUM_PADS-1:0] e_din, e_out, e_oe, e_pu, e_pd, e_val;

	assign pad_in = lvl | frc;

	always #50 clk = ~clk;

	pmx_far_model i_far (.clk_in(clk), .pad_out(lvl), .pval_out(p_val),
		.poe_out(p_oe), .dval_out(d_val), .doe_out(d_oe));

	pmx_pad_matrix i_dut (.CORE_CLK_IN(clk), .RST_IN(rst),
		.PAD_IN_IN(pad_in), .PAD_CFG_IN(pcfg), .OUT_ROUTE_IN(ocfg),
		.IN_ROUTE_IN(icfg), .OE_LO_IN(oe_lo), .OE_HI_IN(oe_hi),
		.PERIPH_OUT_IN(p_val), .PERIPH_OE_IN(p_oe),
		.DIRECT_OUT_IN(d_val), .DIRECT_OE_IN(d_oe), .PERIPH_IN_OUT(o_in),
		.DIRECT_IN_OUT(o_din), .PAD_OUT_OUT(o_out), .PAD_OE_OUT(o_oe),
		.PAD_PU_OUT(o_pu), .PAD_PD_OUT(o_pd), .PAD_VAL_LO_OUT(v_lo),
		.PAD_VAL_HI_OUT(v_hi));

	// ---------------------------------------------------------------
	// Checking
	// ---------------------------------------------------------------
	task automatic check(input logic [PMX_NUM_IN-1:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d, err_count %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Expected outputs from the inputs now applied
	task automatic calc();
		logic [PMX_NUM_PADS-1:0] g, sw;
		logic [PMX_SEL_W-1:0]    s;
		logic                    rt, m;
		sw = {oe_hi, oe_lo};
		for (int p = 0; p < PMX_NUM_PADS; p++) begin
			g[p] = pad_in[p] & PMX_IN_CAPABLE[p] & pcfg[p].ie;
			m = (pcfg[p].func_sel == PMX_FUNC_MATRIX);
			e_pu[p] = pcfg[p].wpu;
			e_pd[p] = pcfg[p].wpd;
			e_din[p] = g[p] & !m;
			e_out[p] = m ? (ocfg[p].out_sel < PMX_NUM_OUT
				? p_val[ocfg[p].out_sel] : 1'b0) : d_val[p];
			e_oe[p] = m ? (ocfg[p].oen_sel ? sw[p] : (ocfg[p].out_sel
				< PMX_NUM_OUT ? p_oe[ocfg[p].out_sel] : 1'b0)) : d_oe[p];
			e_oe[p] = e_oe[p] & PMX_OUT_CAPABLE[p];
		end
		e_val = g;
		for (int i = 0; i < PMX_NUM_IN; i++) begin
			rt = 1'b0;
			for (int r = 0; r < PMX_NUM_RANGES; r++) begin
				rt |= (i >= PMX_RANGE_LO[r] && i <= PMX_RANGE_HI[r]);
			end
			s = icfg[i].sel;
			m = (s < PMX_NUM_PADS) ? g[s] & (pcfg[s].func_sel ==
				PMX_FUNC_MATRIX) : (s == PMX_SEL_CONST1);
			e_in[i] = rt & (m ^ icfg[i].inv);
		end
	endtask

	// ---------------------------------------------------------------
	// Stimulus
	// ---------------------------------------------------------------
	task automatic drive(input bit walk);
		pmx_pad_cfg_t [PMX_NUM_PADS-1:0] tp;
		pmx_out_cfg_t [PMX_NUM_PADS-1:0] to;
		pmx_in_cfg_t  [PMX_NUM_IN-1:0]   ti;
		logic         [PMX_NUM_PADS-1:0] sw, f;
		int                              k;
		sw = PMX_NUM_PADS'({$random(seed), $random(seed)});
		f = '0;
		for (int p = 0; p < PMX_NUM_PADS; p++) begin
			tp[p] = 6'($random(seed));
			if (tp[p].func_sel[0]) tp[p].func_sel = PMX_FUNC_MATRIX;
			to[p] = 9'($random(seed));
		end
		for (int i = 0; i < PMX_NUM_IN; i++) begin
			k = $random(seed);
			ti[i] = 7'($random(seed));
			case (k[1:0])
				2'h0: ti[i].sel = 6'($unsigned(k) % PMX_NUM_PADS);
				2'h1: ti[i].sel = PMX_SEL_CONST0;
				2'h2: ti[i].sel = PMX_SEL_CONST1;
				default: ;
			endcase
		end
		// Software route of pad 15 into several inputs
		if (walk) begin
			tp[15] = {PMX_FUNC_MATRIX, 3'h4};
			to[15].oen_sel = 1'b1;
			sw[15] = 1'b0;
			f[15] = 1'b1;
			ti[83] = {1'b0, 6'h0F};
			ti[84] = {1'b0, 6'h0F};
			ti[85] = {1'b1, 6'h0F};
			ti[20] = {1'b0, 6'h0F};
			ti[0] = {1'b1, PMX_SEL_CONST0};
			ti[1] = {1'b0, PMX_SEL_CONST1};
			tp[35] = {PMX_FUNC_MATRIX, 3'h4};
			to[35].oen_sel = 1'b1;
			sw[35] = 1'b1;
		end
		pcfg <= tp;
		ocfg <= to;
		icfg <= ti;
		{oe_hi, oe_lo} <= sw;
		frc <= f;
	endtask

	// Cycle ceiling against a hang
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			err_count++;
			end_of_test();
		end
	end

	// Main sequence
	initial begin
		seed = 30192;
		{err_count, checks, cyc} = '0;
		rst = 1'b1;
		{frc, pcfg, ocfg, icfg, oe_lo, oe_hi} = '0;
		repeat (6) @(posedge clk);
		#1;
		check(o_in, '0);
		check({o_din, o_out, o_oe}, '0);
		check({o_pu, o_pd, v_hi, v_lo}, '0);
		@(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		calc();
		for (int n = 0; n < 800; n++) begin
			@(posedge clk);
			drive(n % 40 == 3);
			#1;
			check(o_in, e_in);
			check(o_din, e_din);
			check(o_out & PMX_OUT_CAPABLE, e_out & PMX_OUT_CAPABLE);
			check(o_oe, e_oe);
			check({o_pu, o_pd}, {e_pu, e_pd});
			check({v_hi, v_lo}, e_val);
			@(negedge clk);
			calc();
		end
		end_of_test();
	end
endmodule

`default_nettype wire
